// ---- verilog/ispu_pkg.sv ----
package ispu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ISPU_OFS_FORCE = 8'h00;
  localparam logic [7:0] ISPU_OFS_DROP = 8'h04;
  localparam logic [7:0] ISPU_OFS_ENABLE = 8'h08;
  localparam logic [7:0] ISPU_OFS_EVT_STAT = 8'h10;
  localparam logic [7:0] ISPU_OFS_EVT_CLR = 8'h14;
  localparam logic [7:0] ISPU_OFS_EVT_EN = 8'h18;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int ISPU_N_IRQ = 32;
  localparam int ISPU_FIRST_IRQ = 32;
  localparam int ISPU_ADR_W = 8;
  localparam logic [31:0] ISPU_RST_PEND = 32'h0000_0000;
  localparam logic [31:0] ISPU_RST_ENABLE = 32'h0000_0000;
  localparam logic [2:0] ISPU_RST_EVT = 3'h0;

  // ----------------------------------------------------------------
  // Event status field positions
  // ----------------------------------------------------------------
  localparam int ISPU_EVT_FORCED = 0;
  localparam int ISPU_EVT_FORCE_IGN = 1;
  localparam int ISPU_EVT_DROP_IGN = 2;
  localparam int ISPU_N_EVT = 3;

  // Event pulses raised by register writes
  typedef struct packed {
    logic drop_ign;
    logic force_ign;
    logic forced;
  } ispu_evt_t;

endpackage

// ---- verilog/ispu_pend_cell.sv ----
`timescale 1ns/100ps
// One pending flag of one interrupt source
module ispu_pend_cell
  import ispu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_force,
  input wire logic i_drop,
  input wire logic i_hw_set,
  input wire logic i_enabled,
  input wire logic i_active,
  output logic o_pend
);

  logic pend_q;
  logic pend_d;
  logic set_ok;
  logic drop_ok;

  // Force only when enabled and not yet pending
  assign set_ok = (i_force & i_enabled & ~pend_q) | i_hw_set;
  // Drop only when not in service
  assign drop_ok = i_drop & ~i_active;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    pend_d = pend_q;
    if (set_ok)
    begin
      pend_d = 1'b1;
    end
    else if (drop_ok)
    begin
      pend_d = 1'b0;
    end
  end

  // Pending flag
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pend_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  assign o_pend = pend_q;

endmodule

// ---- verilog/ispu_top.sv ----
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module ispu_top
  import ispu_pkg::*;
#(
  parameter int N_IRQ = ISPU_N_IRQ
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ISPU_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [N_IRQ-1:0] i_src_set,
  input wire logic [N_IRQ-1:0] i_src_active,
  output logic [N_IRQ-1:0] o_irq_req,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (N_IRQ < 1 || N_IRQ > 32)
  begin : g_bad_n
    $error("N_IRQ must lie between 1 and 32");
  end

  // Pending cells always clear to zero
  if (ISPU_RST_PEND != 32'h0000_0000)
  begin : g_bad_rst
    $error("Pending reset value must be zero");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Bus side
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic wr_stb;
  logic [31:0] wmask;
  logic [31:0] wbits;
  // Pending and enable state
  logic [N_IRQ-1:0] pend;
  logic [N_IRQ-1:0] force_w;
  logic [N_IRQ-1:0] drop_w;
  logic [N_IRQ-1:0] enable_q;
  // Event logging
  logic [ISPU_N_EVT-1:0] evt_stat_q;
  logic [ISPU_N_EVT-1:0] evt_en_q;
  logic [ISPU_N_EVT-1:0] evt_clr;
  ispu_evt_t evt;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Write takes effect on the edge where ack is high
  assign wr_stb = i_wb_cyc & i_wb_stb & i_wb_we & ack_q;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign wbits = i_wb_dat & wmask;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= i_wb_cyc & i_wb_stb & ~ack_q;
    end
  end

  // Read mux, unmapped reads as zero
  always_comb
  begin
    rdat_d = 32'h0000_0000;
    if (i_wb_adr == ISPU_OFS_FORCE || i_wb_adr == ISPU_OFS_DROP)
    begin
      rdat_d[N_IRQ-1:0] = pend;
    end
    else if (i_wb_adr == ISPU_OFS_ENABLE)
    begin
      rdat_d[N_IRQ-1:0] = enable_q;
    end
    else if (i_wb_adr == ISPU_OFS_EVT_STAT)
    begin
      rdat_d[ISPU_N_EVT-1:0] = evt_stat_q;
    end
    else if (i_wb_adr == ISPU_OFS_EVT_EN)
    begin
      rdat_d[ISPU_N_EVT-1:0] = evt_en_q;
    end
  end

  // Read data captured with the ack
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdat_q <= 32'h0000_0000;
    end
    else if (i_wb_cyc & i_wb_stb & ~i_wb_we & ~ack_q)
    begin
      rdat_q <= rdat_d;
    end
  end

  // Bus outputs straight from flip-flops
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // One-cycle write strobes per source
  // Zero bits of a write touch no cell
  always_comb
  begin
    force_w = '0;
    drop_w = '0;
    evt_clr = '0;
    if (wr_stb && i_wb_adr == ISPU_OFS_FORCE)
    begin
      force_w = wbits[N_IRQ-1:0];
    end
    else if (wr_stb && i_wb_adr == ISPU_OFS_DROP)
    begin
      drop_w = wbits[N_IRQ-1:0];
    end
    else if (wr_stb && i_wb_adr == ISPU_OFS_EVT_CLR)
    begin
      evt_clr = wbits[ISPU_N_EVT-1:0];
    end
  end

  // Enable register, byte lanes honoured
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      enable_q <= ISPU_RST_ENABLE[N_IRQ-1:0];
    end
    else if (wr_stb && i_wb_adr == ISPU_OFS_ENABLE)
    begin
      enable_q <= (enable_q & ~wmask[N_IRQ-1:0]) | wbits[N_IRQ-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pending flags, one cell per source
  // ----------------------------------------------------------------
  // Hardware sets bypass the enable, software forces do not
  for (genvar g = 0; g < N_IRQ; g++)
  begin : g_cell
    ispu_pend_cell u_cell (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_force(force_w[g]),
      .i_drop(drop_w[g]),
      .i_hw_set(i_src_set[g]),
      .i_enabled(enable_q[g]),
      .i_active(i_src_active[g]),
      .o_pend(pend[g])
    );
  end

  // Requests to the priority logic
  assign o_irq_req = pend & enable_q;

  // ----------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------
  // Which writes did or did not take effect
  assign evt.forced = |(force_w & enable_q & ~pend);
  assign evt.force_ign = |(force_w & ~(enable_q & ~pend));
  assign evt.drop_ign = |(drop_w & i_src_active);

  // Sticky status, set wins over clear
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      evt_stat_q <= ISPU_RST_EVT;
    end
    else
    begin
      evt_stat_q <= (evt_stat_q & ~evt_clr) | evt;
    end
  end

  // Event enable register
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      evt_en_q <= ISPU_RST_EVT;
    end
    else if (wr_stb && i_wb_adr == ISPU_OFS_EVT_EN)
    begin
      evt_en_q <= wbits[ISPU_N_EVT-1:0];
    end
  end

  // Level interrupt while an enabled event is flagged
  assign o_irq = |(evt_stat_q & evt_en_q);

endmodule

// ---- testbench/ispu_top_props.sv ----
`timescale 1ns/100ps
module ispu_top_chk
  import ispu_pkg::*;
#(
  parameter int N_IRQ = ISPU_N_IRQ
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ISPU_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [N_IRQ-1:0] i_src_set,
  input wire logic [N_IRQ-1:0] i_src_active,
  input wire logic [N_IRQ-1:0] o_irq_req,
  input wire logic o_irq
);
  // ----------------------------
  // Bus and pending checks
  // ----------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  logic req;
  logic wr;
  // Request and applied write
  assign req = i_wb_cyc && i_wb_stb;
  assign wr = req && o_wb_ack && i_wb_we;
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  ack_resp_a: assert property (req && !o_wb_ack |=> o_wb_ack) else $error("no ack");
  ack_cause_a: assert property (o_wb_ack |-> $past(req)) else $error("stray ack");
  clr_read_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == ISPU_OFS_EVT_CLR
    |-> o_wb_dat == 32'h0) else $error("clear reg read");
  force_keep_a: assert property (wr && i_wb_adr == ISPU_OFS_FORCE
    |=> ($past(o_irq_req) & ~o_irq_req) == '0) else $error("force cleared");
  force_new_a: assert property (wr && i_wb_adr == ISPU_OFS_FORCE
    |=> (o_irq_req & ~$past(o_irq_req | i_wb_dat[N_IRQ-1:0] | i_src_set)) == '0)
    else $error("bad force");
  drop_serv_a: assert property (wr && i_wb_adr == ISPU_OFS_DROP
    |=> ($past(o_irq_req & i_src_active) & ~o_irq_req) == '0) else $error("serviced dropped");
  drop_clr_a: assert property (wr && i_wb_adr == ISPU_OFS_DROP && i_wb_sel == 4'hf
    |=> (o_irq_req & $past(i_wb_dat[N_IRQ-1:0] & ~i_src_active & ~i_src_set)) == '0)
    else $error("drop failed");
  cover property (wr && i_wb_adr == ISPU_OFS_DROP);
  cover property (o_irq);
  cover property (o_wb_ack && !i_wb_we);
endmodule
bind ispu_top ispu_top_chk #(.N_IRQ(N_IRQ)) chk_u (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_src_set(i_src_set), .i_src_active(i_src_active), .o_irq_req(o_irq_req), .o_irq(o_irq));

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
module tb
  import ispu_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, s_set = 32'h0, s_act = 32'h0, o_dat, irq_req;
  logic ack, irq;
  int miscompares = 0, comparisons = 0, cycles = 0;
  // ----------------------------
  // Clock and design
  // ----------------------------
  always #2.5 i_mclk = ~i_mclk;
  ispu_top #(.N_IRQ(32)) dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wb_cyc(req),
    .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(o_dat), .o_wb_ack(ack), .i_src_set(s_set), .i_src_active(s_act),
    .o_irq_req(irq_req), .o_irq(irq));
  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic report_and_stop;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // One classic cycle; data taken and request dropped at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_mclk); while (ack !== 1'b1);
    rdat = o_dat;
    req <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Hang guard
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------
  // Sequence
  // ----------------------------
  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(ISPU_OFS_FORCE, 32'h0);
    wb(1'b1, ISPU_OFS_FORCE, 32'h1);
    rd(ISPU_OFS_FORCE, 32'h0);
    wb(1'b1, ISPU_OFS_ENABLE, 32'hffff_ffff);
    wb(1'b1, ISPU_OFS_FORCE, 32'h8000_0001);
    rd(ISPU_OFS_FORCE, 32'h8000_0001);
    chk(irq_req, 32'h8000_0001);
    wb(1'b1, ISPU_OFS_FORCE, 32'h1);
    wb(1'b1, ISPU_OFS_FORCE, 32'h0);
    rd(ISPU_OFS_DROP, 32'h8000_0001);
    s_act <= 32'h1;
    wb(1'b1, ISPU_OFS_DROP, 32'h8000_0001);
    s_act <= 32'h0;
    rd(ISPU_OFS_FORCE, 32'h1);
    wb(1'b1, ISPU_OFS_DROP, 32'h1);
    rd(ISPU_OFS_FORCE, 32'h0);
    rd(ISPU_OFS_EVT_STAT, 32'h7);
    wb(1'b1, ISPU_OFS_EVT_EN, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, ISPU_OFS_EVT_EN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, ISPU_OFS_EVT_CLR, 32'h7);
    wb(1'b1, ISPU_OFS_EVT_EN, 32'h7);
    chk({31'h0, irq}, 32'h0);
    rd(ISPU_OFS_EVT_STAT, 32'h0);
    rd(ISPU_OFS_EVT_CLR, 32'h0);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    s_set <= 32'h20;
    @(posedge i_mclk);
    s_set <= 32'h0;
    rd(ISPU_OFS_FORCE, 32'h20);
    chk(irq_req, 32'h20);
    wb(1'b1, ISPU_OFS_ENABLE, 32'h0);
    chk(irq_req, 32'h0);
    rd(ISPU_OFS_ENABLE, 32'h0);
    // Lowest byte lane only
    sel <= 4'h1;
    wb(1'b1, ISPU_OFS_ENABLE, 32'hffff_ffff);
    sel <= 4'hf;
    rd(ISPU_OFS_ENABLE, 32'h0000_00ff);
    chk(irq_req, 32'h20);
    // Mid-run reset clears pending and enable state
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(ISPU_OFS_FORCE, 32'h0);
    rd(ISPU_OFS_ENABLE, 32'h0);
    chk(irq_req, 32'h0);
    report_and_stop();
  end
endmodule
